// ==== rtl/cycle_seq_pkg.sv ====
// Shared types and constants of the machine-cycle sequencer
package cycle_seq_pkg;

  // Instructions that the sequencer knows how to walk through
  typedef enum logic [3:0] {
    instr_inc_dec_16                 = 4'h0,
    instr_inc_dec_index              = 4'h1,
    instr_inc_dec_indexed            = 4'h2,
    instr_in_immediate_port          = 4'h3,
    instr_in_register_port           = 4'h4,
    instr_page_zero_port_input       = 4'h5,
    instr_block_input_increment      = 4'h6,
    instr_block_input_decrement      = 4'h7,
    instr_repeat_block_input_increment = 4'h8,
    instr_repeat_block_input_decrement = 4'h9,
    instr_absolute_jump              = 4'ha,
    instr_cond_absolute_jump         = 4'hb,
    instr_jump_hl                    = 4'hc,
    instr_jump_index                 = 4'hd
  } instr_t;

  // Kind of machine cycle on the bus
  typedef enum logic [2:0] {
    cyc_none                = 3'h0,
    cyc_fetch_first         = 3'h1,
    cyc_fetch_second        = 3'h2,
    cyc_mem_read            = 3'h3,
    cyc_mem_write           = 3'h4,
    cyc_io_read             = 3'h5,
    cyc_internal_idle_state = 3'h6,
    cyc_end                 = 3'h7
  } cycle_t;

  // Source of the address lines
  typedef enum logic [2:0] {
    addr_pointer   = 3'h0,
    addr_indexed   = 3'h1,
    addr_bc        = 3'h2,
    addr_hl        = 3'h3,
    addr_port_acc  = 3'h4,
    addr_port_zero = 3'h5
  } addr_sel_t;

  localparam logic [1:0] T_FIRST       = 2'h0;
  localparam logic [1:0] T_LAST_BUS    = 2'h2;
  localparam logic [1:0] T_LAST_IDLE   = 2'h0;
  localparam logic [3:0] MC_FIRST      = 4'h0;
  localparam logic [3:0] MC_STEP       = 4'h1;
  localparam logic [15:0] PTR_STEP     = 16'h0001;
  localparam logic [7:0] PAGE_ZERO_HI  = 8'h00;
  localparam logic [15:0] ADDR_RESET   = 16'h0000;
  localparam logic [7:0] DATA_RESET    = 8'h00;

  // Strobe pattern {rd, wr, memory_request_n, io_request_n, fetch, halt, status}, all active low
  localparam logic [6:0] PAT_QUIET  = 7'h7f;
  localparam logic [6:0] PAT_FETCH1 = 7'h2a;
  localparam logic [6:0] PAT_FETCH2 = 7'h2b;
  localparam logic [6:0] PAT_MEMRD  = 7'h2f;
  localparam logic [6:0] PAT_MEMWR  = 7'h4f;
  localparam logic [6:0] PAT_IORD   = 7'h37;

endpackage : cycle_seq_pkg

// ==== rtl/bus_strobe_driver.sv ====
// Registered bus strobes and data-bus enable for one machine-cycle kind
`timescale 1ns/1ps
module bus_strobe_driver (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic                   clk_en,
  input  wire cycle_seq_pkg::cycle_t  next_kind,
  output logic                        rd_n,
  output logic                        wr_n,
  output logic                        memory_request_n,
  output logic                        io_request_n,
  output logic                        opcode_fetch_indicator_n,
  output logic                        halt_n,
  output logic                        first_fetch_status_n,
  output logic                        data_oe
);

  function automatic logic [6:0] pattern_of(input cycle_seq_pkg::cycle_t kind);
    case (kind)
      cycle_seq_pkg::cyc_fetch_first:  pattern_of = cycle_seq_pkg::PAT_FETCH1;
      cycle_seq_pkg::cyc_fetch_second: pattern_of = cycle_seq_pkg::PAT_FETCH2;
      cycle_seq_pkg::cyc_mem_read:     pattern_of = cycle_seq_pkg::PAT_MEMRD;
      cycle_seq_pkg::cyc_mem_write:    pattern_of = cycle_seq_pkg::PAT_MEMWR;
      cycle_seq_pkg::cyc_io_read:      pattern_of = cycle_seq_pkg::PAT_IORD;
      default:                         pattern_of = cycle_seq_pkg::PAT_QUIET;
    endcase
  endfunction : pattern_of

  // Registered so the pins never glitch; halt is high in every pattern
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      {rd_n, wr_n, memory_request_n, io_request_n,
       opcode_fetch_indicator_n, halt_n, first_fetch_status_n} <= cycle_seq_pkg::PAT_QUIET;
    end else if (clk_en) begin
      {rd_n, wr_n, memory_request_n, io_request_n,
       opcode_fetch_indicator_n, halt_n, first_fetch_status_n} <= pattern_of(next_kind);
    end
  end

  // Data bus floats except while a write cycle drives it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      data_oe <= 1'b0;
    end else if (clk_en) begin
      data_oe <= (next_kind == cycle_seq_pkg::cyc_mem_write);
    end
  end

endmodule : bus_strobe_driver

// ==== rtl/cpu_bus_cycle_sequencer.sv ====
// Machine-cycle sequencer: bus cycles, strobes and address per instruction
`timescale 1ns/1ps
module cpu_bus_cycle_sequencer (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic                   clk_en,
  input  wire logic                   start,
  input  wire cycle_seq_pkg::instr_t  instr,
  input  wire logic                   cond_true,
  input  wire logic                   count_zero,
  input  wire logic [15:0]            pc,
  input  wire logic [7:0]             acc,
  input  wire logic [15:0]            bc,
  input  wire logic [15:0]            hl,
  input  wire logic [15:0]            index_base,
  input  wire logic [7:0]             displacement,
  input  wire logic [7:0]             port_byte,
  input  wire logic [7:0]             write_data,
  output logic                        ready,
  output logic                        done,
  output logic [15:0]                 addr,
  output logic [7:0]                  data_out,
  output logic                        data_oe,
  output logic                        rd_n,
  output logic                        wr_n,
  output logic                        memory_request_n,
  output logic                        io_request_n,
  output logic                        opcode_fetch_indicator_n,
  output logic                        halt_n,
  output logic                        first_fetch_status_n
);

  ////////////////////////////////////////////////////////////////////////////////
  // Cycle tables

  function automatic logic is_repeat(input cycle_seq_pkg::instr_t ins);
    is_repeat = (ins == cycle_seq_pkg::instr_repeat_block_input_increment) ||
                (ins == cycle_seq_pkg::instr_repeat_block_input_decrement);
  endfunction : is_repeat

  // Kind of machine cycle number mc (zero based); cyc_end past the last one
  function automatic cycle_seq_pkg::cycle_t cycle_of(
    input cycle_seq_pkg::instr_t ins,
    input logic [3:0]            mc,
    input logic                  cond,
    input logic                  zero
  );
    cycle_seq_pkg::cycle_t k;
    k = cycle_seq_pkg::cyc_end;
    if (mc == 4'h0) begin
      k = cycle_seq_pkg::cyc_fetch_first;
    end else begin
      case (ins)
        cycle_seq_pkg::instr_inc_dec_16: begin
          if (mc == 4'h1) k = cycle_seq_pkg::cyc_internal_idle_state;
        end
        cycle_seq_pkg::instr_inc_dec_index: begin
          if (mc == 4'h1) k = cycle_seq_pkg::cyc_fetch_second;
          if (mc == 4'h2) k = cycle_seq_pkg::cyc_internal_idle_state;
        end
        cycle_seq_pkg::instr_inc_dec_indexed: begin
          case (mc)
            4'h1:    k = cycle_seq_pkg::cyc_fetch_second;
            4'h2:    k = cycle_seq_pkg::cyc_mem_read;
            4'h3:    k = cycle_seq_pkg::cyc_internal_idle_state;
            4'h4:    k = cycle_seq_pkg::cyc_internal_idle_state;
            4'h5:    k = cycle_seq_pkg::cyc_mem_read;
            4'h6:    k = cycle_seq_pkg::cyc_internal_idle_state;
            4'h7:    k = cycle_seq_pkg::cyc_mem_write;
            default: k = cycle_seq_pkg::cyc_end;
          endcase
        end
        cycle_seq_pkg::instr_in_immediate_port: begin
          if (mc == 4'h1) k = cycle_seq_pkg::cyc_mem_read;
          if (mc == 4'h2) k = cycle_seq_pkg::cyc_io_read;
        end
        cycle_seq_pkg::instr_in_register_port: begin
          if (mc == 4'h1) k = cycle_seq_pkg::cyc_fetch_second;
          if (mc == 4'h2) k = cycle_seq_pkg::cyc_io_read;
        end
        cycle_seq_pkg::instr_page_zero_port_input: begin
          if (mc == 4'h1) k = cycle_seq_pkg::cyc_fetch_second;
          if (mc == 4'h2) k = cycle_seq_pkg::cyc_mem_read;
          if (mc == 4'h3) k = cycle_seq_pkg::cyc_io_read;
        end
        cycle_seq_pkg::instr_block_input_increment,
        cycle_seq_pkg::instr_block_input_decrement,
        cycle_seq_pkg::instr_repeat_block_input_increment,
        cycle_seq_pkg::instr_repeat_block_input_decrement: begin
          if (mc == 4'h1) k = cycle_seq_pkg::cyc_fetch_second;
          if (mc == 4'h2) k = cycle_seq_pkg::cyc_io_read;
          if (mc == 4'h3) k = cycle_seq_pkg::cyc_mem_write;
          if (is_repeat(ins) && !zero && (mc == 4'h4 || mc == 4'h5)) begin
            k = cycle_seq_pkg::cyc_internal_idle_state;
          end
        end
        cycle_seq_pkg::instr_absolute_jump: begin
          if (mc == 4'h1 || mc == 4'h2) k = cycle_seq_pkg::cyc_mem_read;
        end
        cycle_seq_pkg::instr_cond_absolute_jump: begin
          if (mc == 4'h1) k = cycle_seq_pkg::cyc_mem_read;
          if (mc == 4'h2 && cond) k = cycle_seq_pkg::cyc_mem_read;
        end
        cycle_seq_pkg::instr_jump_index: begin
          if (mc == 4'h1) k = cycle_seq_pkg::cyc_fetch_second;
        end
        default: k = cycle_seq_pkg::cyc_end;
      endcase
    end
    cycle_of = k;
  endfunction : cycle_of

  function automatic cycle_seq_pkg::addr_sel_t addr_of(
    input cycle_seq_pkg::instr_t ins,
    input cycle_seq_pkg::cycle_t kind,
    input logic [3:0]            mc
  );
    cycle_seq_pkg::addr_sel_t s;
    s = cycle_seq_pkg::addr_pointer;
    case (kind)
      cycle_seq_pkg::cyc_mem_read: begin
        if (ins == cycle_seq_pkg::instr_inc_dec_indexed && mc == 4'h5) begin
          s = cycle_seq_pkg::addr_indexed;
        end
      end
      cycle_seq_pkg::cyc_mem_write: begin
        s = (ins == cycle_seq_pkg::instr_inc_dec_indexed) ? cycle_seq_pkg::addr_indexed
                                                           : cycle_seq_pkg::addr_hl;
      end
      cycle_seq_pkg::cyc_io_read: begin
        if (ins == cycle_seq_pkg::instr_in_immediate_port) s = cycle_seq_pkg::addr_port_acc;
        else if (ins == cycle_seq_pkg::instr_page_zero_port_input) begin
          s = cycle_seq_pkg::addr_port_zero;
        end else s = cycle_seq_pkg::addr_bc;
      end
      default: s = cycle_seq_pkg::addr_pointer;
    endcase
    addr_of = s;
  endfunction : addr_of

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer state

  cycle_seq_pkg::cycle_t    cur_kind;
  cycle_seq_pkg::cycle_t    next_kind;
  cycle_seq_pkg::cycle_t    follow;
  cycle_seq_pkg::instr_t    cur_instr;
  cycle_seq_pkg::instr_t    next_instr;
  cycle_seq_pkg::addr_sel_t next_sel;
  logic [3:0]               mc;
  logic [3:0]               next_mc;
  logic [1:0]               t_state;
  logic [1:0]               next_t;
  logic [15:0]              ptr;
  logic [15:0]              next_ptr;
  logic [15:0]              start_pc;
  logic [15:0]              next_addr;
  logic                     cond_q;
  logic                     zero_q;
  logic                     busy;
  logic                     last;
  logic                     accept;
  logic                     again;
  logic                     ptr_bump;

  assign busy   = (cur_kind != cycle_seq_pkg::cyc_none);
  // Bus cycles run three clocks, idle states one
  assign last   = (cur_kind == cycle_seq_pkg::cyc_internal_idle_state) ?
                  (t_state == cycle_seq_pkg::T_LAST_IDLE) :
                  (t_state == cycle_seq_pkg::T_LAST_BUS);
  // Repeat decision waits for the count seen at the end of the write cycle
  assign follow = cycle_of(cur_instr, mc + cycle_seq_pkg::MC_STEP, cond_q,
                           (mc == 4'h3) ? count_zero : zero_q);
  assign again  = is_repeat(cur_instr) && !zero_q && (mc != 4'h3);
  assign done   = busy && last && (follow == cycle_seq_pkg::cyc_end) && !again;
  assign ready  = !busy || done;
  assign accept = start && ready;
  assign ptr_bump = last && ((cur_kind == cycle_seq_pkg::cyc_fetch_first) ||
                             (cur_kind == cycle_seq_pkg::cyc_fetch_second) ||
                             ((cur_kind == cycle_seq_pkg::cyc_mem_read) &&
                              (addr_of(cur_instr, cur_kind, mc) == cycle_seq_pkg::addr_pointer)));

  always_comb begin
    next_kind  = cur_kind;
    next_instr = cur_instr;
    next_mc    = mc;
    next_t     = t_state + 2'h1;
    next_ptr   = ptr_bump ? ptr + cycle_seq_pkg::PTR_STEP : ptr;
    if (busy && last) begin
      next_t  = cycle_seq_pkg::T_FIRST;
      next_mc = mc + cycle_seq_pkg::MC_STEP;
      if (follow != cycle_seq_pkg::cyc_end) begin
        next_kind = follow;
      end else if (again) begin
        // Re-run the whole instruction from its own address
        next_kind = cycle_seq_pkg::cyc_fetch_first;
        next_mc   = cycle_seq_pkg::MC_FIRST;
        next_ptr  = start_pc;
      end else begin
        next_kind = cycle_seq_pkg::cyc_none;
      end
    end
    if (!busy) begin
      next_t = cycle_seq_pkg::T_FIRST;
    end
    if (accept) begin
      next_kind  = cycle_seq_pkg::cyc_fetch_first;
      next_instr = instr;
      next_mc    = cycle_seq_pkg::MC_FIRST;
      next_t     = cycle_seq_pkg::T_FIRST;
      next_ptr   = pc;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cur_kind  <= cycle_seq_pkg::cyc_none;
      cur_instr <= cycle_seq_pkg::instr_inc_dec_16;
      mc        <= cycle_seq_pkg::MC_FIRST;
      t_state   <= cycle_seq_pkg::T_FIRST;
      ptr       <= cycle_seq_pkg::ADDR_RESET;
    end else if (clk_en) begin
      cur_kind  <= next_kind;
      cur_instr <= next_instr;
      mc        <= next_mc;
      t_state   <= next_t;
      ptr       <= next_ptr;
    end
  end

  // Per-instruction latches: start address, condition and the count test
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      start_pc <= cycle_seq_pkg::ADDR_RESET;
      cond_q   <= 1'b0;
      zero_q   <= 1'b1;
    end else if (clk_en) begin
      if (accept) begin
        start_pc <= pc;
        cond_q   <= cond_true;
        zero_q   <= 1'b1;
      end else if (busy && last && mc == 4'h3) begin
        zero_q <= count_zero;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address and data outputs

  always_comb begin
    next_sel = addr_of(next_instr, next_kind, next_mc);
    case (next_sel)
      cycle_seq_pkg::addr_indexed:   next_addr = index_base + {{8{displacement[7]}}, displacement};
      cycle_seq_pkg::addr_bc:        next_addr = bc;
      cycle_seq_pkg::addr_hl:        next_addr = hl;
      cycle_seq_pkg::addr_port_acc:  next_addr = {acc, port_byte};
      cycle_seq_pkg::addr_port_zero: begin
        next_addr = {cycle_seq_pkg::PAGE_ZERO_HI, port_byte};
      end
      default:                       next_addr = next_ptr;
    endcase
  end

  // Idle states keep the last address; it carries no meaning then
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      addr <= cycle_seq_pkg::ADDR_RESET;
    end else if (clk_en && next_kind != cycle_seq_pkg::cyc_internal_idle_state &&
                 next_kind != cycle_seq_pkg::cyc_none) begin
      addr <= next_addr;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      data_out <= cycle_seq_pkg::DATA_RESET;
    end else if (clk_en && next_kind == cycle_seq_pkg::cyc_mem_write) begin
      data_out <= write_data;
    end
  end

  bus_strobe_driver strobes (
    .mclk                     (mclk),
    .rst_n                    (rst_n),
    .clk_en                   (clk_en),
    .next_kind                (next_kind),
    .rd_n                     (rd_n),
    .wr_n                     (wr_n),
    .memory_request_n         (memory_request_n),
    .io_request_n             (io_request_n),
    .opcode_fetch_indicator_n (opcode_fetch_indicator_n),
    .halt_n                   (halt_n),
    .first_fetch_status_n     (first_fetch_status_n),
    .data_oe                  (data_oe)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking chk_clk @(posedge mclk iff clk_en); endclocking
  default disable iff (!rst_n);

  first_fetch_a: assert property ($fell(first_fetch_status_n) |->
      (!rd_n && !memory_request_n && !opcode_fetch_indicator_n && wr_n && io_request_n)[*3])
    else $error("first fetch strobes wrong");
  second_fetch_a: assert property ((!opcode_fetch_indicator_n && first_fetch_status_n) |->
      (!rd_n && !memory_request_n && io_request_n && wr_n))
    else $error("second fetch strobes wrong");
  idle_quiet_a: assert property ((busy && cur_kind == cycle_seq_pkg::cyc_internal_idle_state) |->
      (rd_n && wr_n && memory_request_n && io_request_n && !data_oe))
    else $error("idle state not quiet");
  inc16_len_a: assert property ((accept && instr == cycle_seq_pkg::instr_inc_dec_16) |->
      ##4 done)
    else $error("16-bit inc/dec length wrong");
  indexed_len_a: assert property ((accept && instr == cycle_seq_pkg::instr_inc_dec_indexed) |->
      ##15 (rd_n && wr_n) ##1 !wr_n [*3] ##0 done)
    else $error("indexed inc/dec sequence wrong");
  write_back_a: assert property (!wr_n |-> (!memory_request_n && rd_n && data_oe))
    else $error("write cycle strobes wrong");
  io_read_a: assert property (!io_request_n |->
      (!rd_n && memory_request_n && wr_n && opcode_fetch_indicator_n))
    else $error("io read strobes wrong");
  cond_false_a: assert property ((accept && instr == cycle_seq_pkg::instr_cond_absolute_jump &&
      !cond_true) |-> ##6 done)
    else $error("false conditional jump length wrong");
  read_len_a: assert property ($fell(rd_n) |-> !rd_n [*3])
    else $error("bus cycle shorter than three states");
  halt_high_a: assert property (halt_n)
    else $error("halt output asserted");

endmodule : cpu_bus_cycle_sequencer

// ==== sim/bus_device_model.sv ====
// Behavioural memory and I/O device watching the sequencer's bus strobes
`timescale 1ns/1ps
module bus_device_model (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic rd_n,
  input  wire logic wr_n,
  input  wire logic memory_request_n,
  input  wire logic io_request_n,
  output int        clash_count,
  output int        io_read_states
);
  // No data pins reach this block, so the device can only judge strobe combinations
  always @(posedge mclk) begin
    if (!rst_n) begin
      clash_count    <= 0;
      io_read_states <= 0;
    end else begin
      if ((!rd_n && !wr_n) || (!memory_request_n && !io_request_n)) begin
        clash_count <= clash_count + 1;
      end
      if (!io_request_n && !rd_n) begin
        io_read_states <= io_read_states + 1;
      end
    end
  end
endmodule : bus_device_model

// ==== sim/cpu_bus_cycle_sequencer_bench.sv ====
// Self-checking bench walking every instruction through its bus cycles
`timescale 1ns/1ps
module cpu_bus_cycle_sequencer_bench;
  logic mclk, rst_n, clk_en, start, cond_true, count_zero;
  cycle_seq_pkg::instr_t instr;
  logic [15:0] pc, bc, hl, index_base, addr;
  logic [7:0]  acc, displacement, port_byte, write_data, data_out;
  logic ready, done, data_oe, rd_n, wr_n, memory_request_n, io_request_n;
  logic opcode_fetch_indicator_n, halt_n, first_fetch_status_n;
  int   bad_count, n_compared, clash_count, io_read_states;

  cpu_bus_cycle_sequencer dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .start(start),
    .instr(instr), .cond_true(cond_true), .count_zero(count_zero), .pc(pc), .acc(acc),
    .bc(bc), .hl(hl), .index_base(index_base), .displacement(displacement),
    .port_byte(port_byte), .write_data(write_data), .ready(ready), .done(done),
    .addr(addr), .data_out(data_out), .data_oe(data_oe), .rd_n(rd_n), .wr_n(wr_n),
    .memory_request_n(memory_request_n), .io_request_n(io_request_n),
    .opcode_fetch_indicator_n(opcode_fetch_indicator_n), .halt_n(halt_n),
    .first_fetch_status_n(first_fetch_status_n));

  bus_device_model partner (.mclk(mclk), .rst_n(rst_n), .rd_n(rd_n), .wr_n(wr_n),
    .memory_request_n(memory_request_n), .io_request_n(io_request_n),
    .clash_count(clash_count), .io_read_states(io_read_states));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  // Strobes {rd, wr, memory_request_n, io_request_n, fetch, halt, status} for each cycle letter
  function automatic logic [6:0] pattern(input byte c);
    case (c)
      "F":     return 7'h2a;
      "S":     return 7'h2b;
      "R", "X": return 7'h2f;
      "Y", "H": return 7'h4f;
      "B", "P", "Z": return 7'h37;
      default: return 7'h7f;
    endcase
  endfunction : pattern

  // Letters: F/S fetches, R pointer read, X/Y indexed read/write, B/P/Z I/O reads,
  // H write at HL, i idle state
  task automatic run(input cycle_seq_pkg::instr_t ins, input logic cond, input logic cz,
                     input string seq);
    logic [15:0] ptr;
    logic [15:0] a;
    int          n;
    byte         c;
    ptr = pc;
    a   = 16'h0000;
    @(posedge mclk);
    instr      <= ins;
    cond_true  <= cond;
    count_zero <= cz;
    start      <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    for (int k = 0; k < seq.len(); k++) begin
      c = seq[k];
      if (c == "F") ptr = pc;
      case (c)
        "F", "S", "R": begin
          a   = ptr;
          ptr = ptr + 16'h0001;
        end
        "X", "Y": a = index_base + {8'h00, displacement};
        "B":      a = bc;
        "H":      a = hl;
        "P":      a = {acc, port_byte};
        "Z":      a = {8'h00, port_byte};
        default:  a = a;
      endcase
      n = (c == "i") ? 1 : 3;
      for (int t = 0; t < n; t++) begin
        @(negedge mclk);
        check("strobes", {9'h000, rd_n, wr_n, memory_request_n, io_request_n,
              opcode_fetch_indicator_n, halt_n, first_fetch_status_n},
              {9'h000, pattern(c)});
        if (c != "i") check("addr", addr, a);
        check("data_oe", {15'h0000, data_oe}, {15'h0000, c == "Y" || c == "H"});
        if (c == "Y" || c == "H") begin
          check("data_out", {8'h00, data_out}, {8'h00, write_data});
        end
        check("done", {15'h0000, done}, {15'h0000, k == seq.len() - 1 && t == n - 1});
      end
      // Count reaches zero after every idle state, so the repeated pass ends after its write, with no trailing idles
      if (c == "i") @(posedge mclk) count_zero <= 1'b1;
    end
  endtask : run

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset_state;
    check("reset strobes", {9'h000, rd_n, wr_n, memory_request_n, io_request_n,
          opcode_fetch_indicator_n, halt_n, first_fetch_status_n}, 16'h007f);
    check("reset addr", addr, 16'h0000);
    check("reset ready", {15'h0000, ready}, 16'h0001);
  endtask : test_reset_state

  task automatic test_inc_dec;
    run(cycle_seq_pkg::instr_inc_dec_16, 1'b0, 1'b0, "Fi");
    run(cycle_seq_pkg::instr_inc_dec_index, 1'b0, 1'b0, "FSi");
    run(cycle_seq_pkg::instr_inc_dec_indexed, 1'b0, 1'b0, "FSRiiXiY");
  endtask : test_inc_dec

  task automatic test_input;
    run(cycle_seq_pkg::instr_in_immediate_port, 1'b0, 1'b0, "FRP");
    run(cycle_seq_pkg::instr_in_register_port, 1'b0, 1'b0, "FSB");
    run(cycle_seq_pkg::instr_page_zero_port_input, 1'b0, 1'b0, "FSRZ");
    run(cycle_seq_pkg::instr_block_input_increment, 1'b0, 1'b0, "FSBH");
    run(cycle_seq_pkg::instr_block_input_decrement, 1'b0, 1'b1, "FSBH");
    run(cycle_seq_pkg::instr_repeat_block_input_increment, 1'b0, 1'b1, "FSBH");
    run(cycle_seq_pkg::instr_repeat_block_input_decrement, 1'b0, 1'b0, "FSBHiiFSBH");
  endtask : test_input

  task automatic test_jumps;
    run(cycle_seq_pkg::instr_absolute_jump, 1'b0, 1'b0, "FRR");
    run(cycle_seq_pkg::instr_cond_absolute_jump, 1'b0, 1'b0, "FR");
    run(cycle_seq_pkg::instr_cond_absolute_jump, 1'b1, 1'b0, "FRR");
    run(cycle_seq_pkg::instr_jump_hl, 1'b0, 1'b0, "F");
    run(cycle_seq_pkg::instr_jump_index, 1'b0, 1'b0, "FS");
  endtask : test_jumps

  // Low clock enable must hold the first fetch in its first state
  task automatic test_freeze;
    @(posedge mclk);
    instr <= cycle_seq_pkg::instr_jump_hl;
    start <= 1'b1;
    @(posedge mclk);
    start  <= 1'b0;
    clk_en <= 1'b0;
    for (int t = 0; t < 7; t++) begin
      @(negedge mclk);
      check("frozen strobes", {9'h000, rd_n, wr_n, memory_request_n, io_request_n,
            opcode_fetch_indicator_n, halt_n, first_fetch_status_n},
            {9'h000, pattern("F")});
      check("frozen addr", addr, pc);
      check("frozen done", {15'h0000, done}, {15'h0000, t == 6});
      if (t == 3) @(posedge mclk) clk_en <= 1'b1;
    end
  endtask : test_freeze

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    #100000;
    bad_count++;
    conclude();
  end

  initial begin
    bad_count  = 0;
    n_compared = 0;
    rst_n = 1'b0;  clk_en = 1'b1;  start = 1'b0;  cond_true = 1'b0;  count_zero = 1'b0;
    instr = cycle_seq_pkg::instr_inc_dec_16;
    pc = 16'h1000;  bc = 16'h2345;  hl = 16'h4c00;  index_base = 16'h8000;
    acc = 8'h5a;  displacement = 8'h12;  port_byte = 8'h3c;  write_data = 8'ha5;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    test_reset_state();
    test_inc_dec();
    test_input();
    test_jumps();
    test_freeze();
    @(negedge mclk);
    check("bus clashes", clash_count[15:0], 16'h0000);
    check("io read states", io_read_states[15:0], 16'h0018);
    conclude();
  end
endmodule : cpu_bus_cycle_sequencer_bench
